// *** logic/gds_gpio.sv ***
// keypad-pin gpio: data/mask, direction, sense and polarity registers
// register port driven by the device's serial slave on mclk_i;
// pins are asynchronous and resolved by the testbench from out/oe
`timescale 1ns/1ps
module gds_gpio
    import gds_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [GDS_ADDR_W-1:0] reg_addr_i,
    input wire logic [GDS_DATA_W-1:0] reg_wdata_i,
    output logic [GDS_DATA_W-1:0] reg_rdata_o,
    output logic reg_rack_o,
    // column pins
    input wire logic [GDS_COL_N-1:0] col_in_i,
    output logic [GDS_COL_N-1:0] col_out_o,
    output logic [GDS_COL_N-1:0] col_oe_o,
    // row pins
    input wire logic [GDS_ROW_N-1:0] row_in_i,
    output logic [GDS_ROW_N-1:0] row_out_o,
    output logic [GDS_ROW_N-1:0] row_oe_o,
    // per-pin interrupt condition, columns then rows
    output logic [GDS_PIN_N-1:0] irq_cond_o
);

    // pin vector order: col[7:0], row[7:0], row[11:8]
    logic [GDS_PIN_N-1:0] dir_r;
    logic [GDS_PIN_N-1:0] dir_nxt;
    logic [GDS_PIN_N-1:0] sense_r;
    logic [GDS_PIN_N-1:0] sense_nxt;
    logic [GDS_PIN_N-1:0] pol_r;
    logic [GDS_PIN_N-1:0] pol_nxt;
    logic [GDS_PIN_N-1:0] mask_r;
    logic [GDS_PIN_N-1:0] mask_nxt;
    logic [GDS_PIN_N-1:0] out_r;
    logic [GDS_PIN_N-1:0] out_nxt;
    logic [GDS_DATA_W-1:0] rdata_r;
    logic [GDS_DATA_W-1:0] rdata_nxt;
    logic rack_r;
    logic [GDS_PIN_N-1:0] lvl_w;
    logic [GDS_PIN_N-1:0] cond_w;

    // address decode, one lane select per register group
    wire [2:0] a_data_w = gds_hit3(reg_addr_i, GDS_COL_DATA_OFS, GDS_RLO_DATA_OFS,
                                   GDS_RHI_DATA_OFS);
    wire [2:0] a_dir_w = gds_hit3(reg_addr_i, GDS_COL_DIR_OFS, GDS_RLO_DIR_OFS,
                                  GDS_RHI_DIR_OFS);
    wire [2:0] a_sense_w = gds_hit3(reg_addr_i, GDS_COL_SENSE_OFS, GDS_RLO_SENSE_OFS,
                                    GDS_RHI_SENSE_OFS);
    wire [2:0] a_pol_w = gds_hit3(reg_addr_i, GDS_COL_POL_OFS, GDS_RLO_POL_OFS,
                                  GDS_RHI_POL_OFS);

    wire [2:0] w_data_w = reg_wr_i ? a_data_w : 3'b000;
    wire [2:0] w_dir_w = reg_wr_i ? a_dir_w : 3'b000;
    wire [2:0] w_sense_w = reg_wr_i ? a_sense_w : 3'b000;
    wire [2:0] w_pol_w = reg_wr_i ? a_pol_w : 3'b000;

    wire [7:0] wmask_w = reg_wdata_i[GDS_MASK_MSB:GDS_MASK_LSB];
    wire [7:0] wdat_w = reg_wdata_i[GDS_DAT_MSB:GDS_DAT_LSB];
    wire [7:0] wlow_w = reg_wdata_i[GDS_DAT_MSB:GDS_DAT_LSB];

    // written mask bits on output pins only
    wire [GDS_PIN_N-1:0] wr_mask_w = gds_lanes(w_data_w, wmask_w);
    wire [GDS_PIN_N-1:0] wr_dat_w = gds_lanes(w_data_w, wdat_w);
    wire [GDS_PIN_N-1:0] gate_w = wr_mask_w & dir_r;

    assign out_nxt = (out_r & ~gate_w) | (wr_dat_w & gate_w);
    assign mask_nxt = gds_upd(mask_r, w_data_w, wmask_w);
    assign dir_nxt = gds_upd(dir_r, w_dir_w, wlow_w);
    assign sense_nxt = gds_upd(sense_r, w_sense_w, wlow_w);
    assign pol_nxt = gds_upd(pol_r, w_pol_w, wlow_w);

    // read mux: data field is the synchronised pin level
    wire [GDS_DATA_W-1:0] rd_data_w = (gds_rd8(a_data_w, mask_r) << GDS_MASK_LSB)
                                      | gds_rd8(a_data_w, lvl_w);
    wire [GDS_DATA_W-1:0] rd_cfg_w = gds_rd8(a_dir_w, dir_r) | gds_rd8(a_sense_w, sense_r)
                                     | gds_rd8(a_pol_w, pol_r);

    assign rdata_nxt = reg_rd_i ? (rd_data_w | rd_cfg_w) : rdata_r;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_r <= GDS_DIR_RST;
            sense_r <= GDS_CLR20;
            pol_r <= GDS_POL_RST;
            mask_r <= GDS_CLR20;
            out_r <= GDS_CLR20;
        end else begin
            dir_r <= dir_nxt;
            sense_r <= sense_nxt;
            pol_r <= pol_nxt;
            mask_r <= mask_nxt;
            out_r <= out_nxt;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= GDS_ZERO16;
            rack_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rack_r <= reg_rd_i;
        end
    end

    gds_pin_sense u_sense (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .pin_i({row_in_i, col_in_i}),
        .dir_i(dir_r),
        .sense_i(sense_r),
        .pol_i(pol_r),
        .level_o(lvl_w),
        .cond_o(cond_w)
    );

    // pin drive: enable follows direction
    assign col_out_o = out_r[GDS_COL_MSB:GDS_COL_LSB];
    assign col_oe_o = dir_r[GDS_COL_MSB:GDS_COL_LSB];
    assign row_out_o = out_r[GDS_RHI_MSB:GDS_RLO_LSB];
    assign row_oe_o = dir_r[GDS_RHI_MSB:GDS_RLO_LSB];
    assign irq_cond_o = cond_w;
    assign reg_rdata_o = rdata_r;
    assign reg_rack_o = rack_r;

    // assertion helpers
    wire [7:0] col_gate_w = wmask_w & dir_r[GDS_COL_MSB:GDS_COL_LSB];
    wire [7:0] col_out_w = out_r[GDS_COL_MSB:GDS_COL_LSB];
    wire [7:0] col_lvl_w = lvl_w[GDS_COL_MSB:GDS_COL_LSB];
    wire [7:0] col_in_dir_w = ~dir_r[GDS_COL_MSB:GDS_COL_LSB];
    wire [7:0] rlo_mask_w = mask_r[GDS_RLO_MSB:GDS_RLO_LSB];
    wire [3:0] rhi_dir_w = dir_r[GDS_RHI_MSB:GDS_RHI_LSB];
    wire [3:0] wnib_w = reg_wdata_i[GDS_RHI_N-1:0];
    wire [3:0] rhi_oe_w = row_oe_o[GDS_ROW_N-1:GDS_RLO_MSB-GDS_RLO_LSB+1];
    wire unmapped_w = ~|{a_data_w, a_dir_w, a_sense_w, a_pol_w};
    wire [3:0] wmask_hi_w = reg_wdata_i[GDS_MASK_LSB+GDS_RHI_N-1:GDS_MASK_LSB];
    wire [3:0] rhi_gate_w = wmask_hi_w & rhi_dir_w;
    wire [3:0] rhi_out_w = out_r[GDS_RHI_MSB:GDS_RHI_LSB];
    wire [3:0] rhi_lvl_w = lvl_w[GDS_RHI_MSB:GDS_RHI_LSB];
    wire [3:0] rhi_sense_w = sense_r[GDS_RHI_MSB:GDS_RHI_LSB];
    wire [7:0] rlo_gate_w = wmask_w & dir_r[GDS_RLO_MSB:GDS_RLO_LSB];
    wire [7:0] rlo_out_w = out_r[GDS_RLO_MSB:GDS_RLO_LSB];
    wire [15:0] dir_lo_w = dir_r[GDS_RLO_MSB:GDS_COL_LSB];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence col_wr_s;
        reg_wr_i && (reg_addr_i == GDS_COL_DATA_OFS);
    endsequence

    sequence rd_s(logic [7:0] ofs);
        reg_rd_i && (reg_addr_i == ofs);
    endsequence

    sequence wr_s(logic [7:0] ofs);
        reg_wr_i && (reg_addr_i == ofs);
    endsequence

    sequence rd_pulse_s;
        reg_rd_i ##1 !reg_rd_i;
    endsequence

    masked_write_a: assert property (
        col_wr_s |=> ((col_out_w ^ $past(wdat_w)) & $past(col_gate_w)) == 8'h00
                     && ((col_out_w ^ $past(col_out_w)) & ~$past(col_gate_w)) == 8'h00
    ) else $error("masked write drove the wrong column levels");

    input_untouched_a: assert property (
        $changed(out_r) |-> ((out_r ^ $past(out_r)) & ~$past(dir_r)) == GDS_CLR20
    ) else $error("output latch of an input pin changed");

    input_read_pin_a: assert property (
        rd_s(GDS_COL_DATA_OFS) |=>
            reg_rack_o && ((reg_rdata_o[GDS_DAT_MSB:GDS_DAT_LSB] ^ $past(col_lvl_w))
                           & $past(col_in_dir_w)) == 8'h00
    ) else $error("pin read did not return the pin level");

    row_low_layout_a: assert property (
        rd_s(GDS_RLO_DATA_OFS) |=>
            reg_rdata_o[GDS_MASK_MSB:GDS_MASK_LSB] == $past(rlo_mask_w)
    ) else $error("row low mask field misplaced");

    row_high_rsvd_a: assert property (
        rd_s(GDS_RHI_DATA_OFS) ##1 reg_rack_o |-> (reg_rdata_o & GDS_RHI_RSVD) == GDS_ZERO16
    ) else $error("reserved bits of row high word not zero");

    reset_state_a: assert property (
        $rose(rst_b_i) |-> dir_r == GDS_DIR_RST && sense_r == GDS_CLR20
                           && mask_r == GDS_CLR20 && out_r == GDS_CLR20
    ) else $error("register reset values wrong");

    dir_high_write_a: assert property (
        reg_wr_i && reg_addr_i == GDS_RHI_DIR_OFS |=>
            rhi_dir_w == $past(wnib_w) ##0 rhi_oe_w == rhi_dir_w
    ) else $error("row high direction write not applied");

    sense_write_a: assert property (
        reg_wr_i && reg_addr_i == GDS_COL_SENSE_OFS |=>
            sense_r[GDS_COL_MSB:GDS_COL_LSB] == $past(wlow_w)
    ) else $error("column sense write not applied");

    unmapped_read_a: assert property (
        reg_rd_i && unmapped_w |=> reg_rack_o && reg_rdata_o == GDS_ZERO16
    ) else $error("unmapped read returned nonzero");

    // write side and polarity reset
    row_low_write_a: assert property (
        wr_s(GDS_RLO_DATA_OFS) |=>
            ((rlo_out_w ^ $past(wdat_w)) & $past(rlo_gate_w)) == 8'h00
            && ((rlo_out_w ^ $past(rlo_out_w)) & ~$past(rlo_gate_w)) == 8'h00
    ) else $error("masked write drove the wrong row low levels");

    row_high_write_a: assert property (
        wr_s(GDS_RHI_DATA_OFS) |=>
            ((rhi_out_w ^ $past(wnib_w)) & $past(rhi_gate_w)) == 4'h0
            && ((rhi_out_w ^ $past(rhi_out_w)) & ~$past(rhi_gate_w)) == 4'h0
    ) else $error("masked write drove the wrong row high levels");

    mask_store_a: assert property (
        col_wr_s |=> mask_r[GDS_COL_MSB:GDS_COL_LSB] == $past(wmask_w)
    ) else $error("column mask field not stored");

    col_dir_write_a: assert property (
        wr_s(GDS_COL_DIR_OFS) |=> col_oe_o == $past(wlow_w)
    ) else $error("column direction write not applied");

    dir_low_write_a: assert property (
        wr_s(GDS_RLO_DIR_OFS) |=> dir_r[GDS_RLO_MSB:GDS_RLO_LSB] == $past(wlow_w)
    ) else $error("row low direction write not applied");

    dir_rsvd_keep_a: assert property (
        wr_s(GDS_RHI_DIR_OFS) |=> dir_lo_w == $past(dir_lo_w)
    ) else $error("row high direction write touched other lanes");

    pol_write_a: assert property (
        wr_s(GDS_COL_POL_OFS) |=> pol_r[GDS_COL_MSB:GDS_COL_LSB] == $past(wlow_w)
    ) else $error("column polarity write not applied");

    pol_reset_a: assert property (
        $rose(rst_b_i) |-> pol_r == GDS_POL_RST
    ) else $error("polarity reset value wrong");

    unmapped_write_a: assert property (
        reg_wr_i && unmapped_w |=> $stable(dir_r) && $stable(sense_r) && $stable(pol_r)
                                   && $stable(mask_r) && $stable(out_r)
    ) else $error("unmapped write changed a register");

    idle_hold_a: assert property (
        !reg_wr_i |=> $stable(out_r) && $stable(dir_r) && $stable(mask_r)
    ) else $error("pin latch changed without a write");

    // read side and output-pin condition
    sense_high_read_a: assert property (
        rd_s(GDS_RHI_SENSE_OFS) |=>
            reg_rdata_o[GDS_RHI_N-1:0] == $past(rhi_sense_w)
            && reg_rdata_o[GDS_DATA_W-1:GDS_RHI_N] == '0
    ) else $error("row high sense read layout wrong");

    pol_high_read_a: assert property (
        rd_s(GDS_RHI_POL_OFS) |=> reg_rdata_o[GDS_DATA_W-1:GDS_RHI_N] == '0
    ) else $error("row high polarity reserved bits not zero");

    row_high_read_a: assert property (
        rd_s(GDS_RHI_DATA_OFS) |=> reg_rdata_o[GDS_RHI_N-1:0] == $past(rhi_lvl_w)
    ) else $error("row high read did not return the pin state");

    col_mask_read_a: assert property (
        rd_s(GDS_COL_DATA_OFS) |=>
            reg_rdata_o[GDS_MASK_MSB:GDS_MASK_LSB] == $past(mask_r[GDS_COL_MSB:GDS_COL_LSB])
    ) else $error("column mask field misplaced");

    rack_pulse_a: assert property (
        rd_pulse_s |-> reg_rack_o ##1 !reg_rack_o
    ) else $error("read answer not a single pulse");

    rdata_hold_a: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)
    ) else $error("read data moved without a read");

    output_no_cond_a: assert property (
        (irq_cond_o & $past(dir_r)) == GDS_CLR20
    ) else $error("output pin raised an interrupt condition");

endmodule

// *** logic/gds_pin_sense.sv ***
// pin synchroniser and per-pin interrupt condition
// pins are asynchronous; config comes from the gpio registers on mclk_i
`timescale 1ns/1ps
module gds_pin_sense
    import gds_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // pins and configuration
    input wire logic [GDS_PIN_N-1:0] pin_i,
    input wire logic [GDS_PIN_N-1:0] dir_i,
    input wire logic [GDS_PIN_N-1:0] sense_i,
    input wire logic [GDS_PIN_N-1:0] pol_i,
    // synchronised level and condition
    output logic [GDS_PIN_N-1:0] level_o,
    output logic [GDS_PIN_N-1:0] cond_o
);

    logic [GDS_PIN_N-1:0] s1_r;
    logic [GDS_PIN_N-1:0] s2_r;
    logic [GDS_PIN_N-1:0] s3_r;
    logic [GDS_PIN_N-1:0] cond_r;
    logic [GDS_PIN_N-1:0] cond_nxt;
    logic p1_r;
    logic p2_r;
    logic p3_r;
    wire [GDS_PIN_N-1:0] now_act_w = ~(s2_r ^ pol_i);
    wire [GDS_PIN_N-1:0] was_act_w = ~(s3_r ^ pol_i);
    // no edge until s3_r holds a real sample, else a pin held active
    // through reset looks like a fresh edge
    wire [GDS_PIN_N-1:0] seen_w = {GDS_PIN_N{p3_r}};

    // level mode holds while active, edge mode fires on entry only
    assign cond_nxt = ~dir_i & now_act_w & (sense_i | (seen_w & ~was_act_w));

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r <= GDS_CLR20;
            s2_r <= GDS_CLR20;
            s3_r <= GDS_CLR20;
            cond_r <= GDS_CLR20;
            p1_r <= 1'b0;
            p2_r <= 1'b0;
            p3_r <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            cond_r <= cond_nxt;
            p1_r <= 1'b1;
            p2_r <= p1_r;
            p3_r <= p2_r;
        end
    end

    assign level_o = s2_r;
    assign cond_o = cond_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence lvl_held_s;
        (sense_i[GDS_COL_MSB] && !dir_i[GDS_COL_MSB] && (s2_r[GDS_COL_MSB] == pol_i[GDS_COL_MSB])
         && $stable(pol_i[GDS_COL_MSB]))[*2];
    endsequence

    level_hold_a: assert property (
        lvl_held_s |=> cond_o[GDS_COL_MSB]
    ) else $error("level-sensitive pin lost its condition");

    edge_cause_a: assert property (
        cond_o[GDS_COL_MSB] && $past(!sense_i[GDS_COL_MSB]) |->
            ($past(s2_r[GDS_COL_MSB]) == $past(pol_i[GDS_COL_MSB]))
            && ($past(s3_r[GDS_COL_MSB]) != $past(pol_i[GDS_COL_MSB]))
            && $past(!dir_i[GDS_COL_MSB])
    ) else $error("edge condition without an active edge");

endmodule

// *** logic/gds_pkg.sv ***
// constants, register map and helpers of the keypad-pin gpio block
// shared by the gpio top and its pin sense module
package gds_pkg;

    localparam int GDS_ADDR_W = 8;
    localparam int GDS_DATA_W = 16;
    localparam int GDS_COL_N = 8;
    localparam int GDS_ROW_N = 12;
    localparam int GDS_RHI_N = 4;
    localparam int GDS_PIN_N = 20;

    // field positions inside a 16-bit data/mask word
    localparam int GDS_DAT_MSB = 7;
    localparam int GDS_DAT_LSB = 0;
    localparam int GDS_MASK_MSB = 15;
    localparam int GDS_MASK_LSB = 8;

    // lanes of the 20-pin vector: columns, row low, row high
    localparam int GDS_COL_MSB = 7;
    localparam int GDS_COL_LSB = 0;
    localparam int GDS_RLO_MSB = 15;
    localparam int GDS_RLO_LSB = 8;
    localparam int GDS_RHI_MSB = 19;
    localparam int GDS_RHI_LSB = 16;

    // register offsets
    localparam logic [7:0] GDS_COL_DATA_OFS = 8'hc0;
    localparam logic [7:0] GDS_RLO_DATA_OFS = 8'hc2;
    localparam logic [7:0] GDS_RHI_DATA_OFS = 8'hc4;
    localparam logic [7:0] GDS_COL_DIR_OFS = 8'hc6;
    localparam logic [7:0] GDS_RLO_DIR_OFS = 8'hc7;
    localparam logic [7:0] GDS_RHI_DIR_OFS = 8'hc8;
    localparam logic [7:0] GDS_COL_SENSE_OFS = 8'hc9;
    localparam logic [7:0] GDS_RLO_SENSE_OFS = 8'hca;
    localparam logic [7:0] GDS_RHI_SENSE_OFS = 8'hcb;
    localparam logic [7:0] GDS_COL_POL_OFS = 8'hcf;
    localparam logic [7:0] GDS_RLO_POL_OFS = 8'hd0;
    localparam logic [7:0] GDS_RHI_POL_OFS = 8'hd1;

    // reset values
    localparam logic [7:0] GDS_DIR_LO_RST = 8'h00;
    localparam logic [3:0] GDS_DIR_RHI_RST = 4'h8;
    localparam logic [19:0] GDS_DIR_RST = {GDS_DIR_RHI_RST, GDS_DIR_LO_RST, GDS_DIR_LO_RST};
    localparam logic [19:0] GDS_POL_RST = 20'hf_ffff;
    localparam logic [19:0] GDS_CLR20 = 20'h0_0000;
    localparam logic [15:0] GDS_ZERO16 = 16'h0000;
    localparam logic [15:0] GDS_RHI_RSVD = 16'hf0f0;
    localparam logic [7:0] GDS_ALL8 = 8'hff;

    // one-hot lane select of an address among three offsets
    function automatic logic [2:0] gds_hit3(input logic [7:0] a, input logic [7:0] o0,
                                            input logic [7:0] o1, input logic [7:0] o2);
        return {a == o2, a == o1, a == o0};
    endfunction

    // spread an 8-bit value onto the selected lane of the pin vector
    function automatic logic [19:0] gds_lanes(input logic [2:0] sel, input logic [7:0] v);
        return {sel[2] ? v[GDS_RHI_N-1:0] : {GDS_RHI_N{1'b0}},
                sel[1] ? v : 8'h00,
                sel[0] ? v : 8'h00};
    endfunction

    // replace the selected lane, reserved high-row bits dropped
    function automatic logic [19:0] gds_upd(input logic [19:0] old, input logic [2:0] sel,
                                            input logic [7:0] v);
        return (old & ~gds_lanes(sel, GDS_ALL8)) | gds_lanes(sel, v);
    endfunction

    // selected lane of the pin vector, zero-extended
    function automatic logic [15:0] gds_rd8(input logic [2:0] sel, input logic [19:0] vec);
        logic [15:0] r;
        r = GDS_ZERO16;
        if (sel[0]) r = {8'h00, vec[GDS_COL_MSB:GDS_COL_LSB]};
        if (sel[1]) r = {8'h00, vec[GDS_RLO_MSB:GDS_RLO_LSB]};
        if (sel[2]) r = {12'h000, vec[GDS_RHI_MSB:GDS_RHI_LSB]};
        return r;
    endfunction

endpackage

// *** tb/gds_gpio_test.sv ***
// self-checking bench of the keypad-pin gpio block
// drives the parallel register port and the pin model at the falling edge
`timescale 1ns/1ps
module gds_gpio_test;
    import gds_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdat = 16'h0000;
    logic [15:0] rdat;
    logic rack;
    logic [7:0] col_out, col_oe;
    logic [11:0] row_out, row_oe;
    logic [19:0] irq, lvl;
    logic [19:0] ext_val = 20'h0_0000;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    // post-reset reads: address, expected word
    localparam logic [23:0] ROWS [13] = '{24'hc0_0000, 24'hc2_0000, 24'hc4_0000,
        24'hc6_0000, 24'hc7_0000, 24'hc8_0008, 24'hc9_0000, 24'hca_0000,
        24'hcb_0000, 24'hc5_0000, 24'hcf_00ff, 24'hd1_000f, 24'hd0_00ff};

    always #4 mclk_i = ~mclk_i;

    gds_gpio u_gds_gpio (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdat), .reg_rack_o(rack),
        .col_in_i(lvl[7:0]), .col_out_o(col_out), .col_oe_o(col_oe),
        .row_in_i(lvl[19:8]), .row_out_o(row_out), .row_oe_o(row_oe), .irq_cond_o(irq));

    gds_pins_model u_gds_pins_model (.mclk_i(mclk_i), .dev_out_i({row_out, col_out}),
        .dev_oe_i({row_oe, col_oe}), .ext_en_i(20'hf_ffff), .ext_val_i(ext_val),
        .lvl_o(lvl));

    task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        wr = 1'b1;
        addr = a;
        wdat = d;
        @(negedge mclk_i);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(negedge mclk_i);
        rd = 1'b1;
        addr = a;
        @(negedge mclk_i);
        rd = 1'b0;
        chk("read answer", 20'h1, {19'h0, rack});
        chk($sformatf("read %h", a), {4'h0, exp}, {4'h0, rdat});
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        wait_n(4);
        chk("oe in reset", 20'h8_0000, {row_oe, col_oe});
        chk("out in reset", 20'h0, {row_out, col_out});
        rst_b_i = 1'b1;
        for (int i = 0; i < 13; i++) begin
            rd_chk(ROWS[i][23:16], ROWS[i][15:0]);
        end
        wr_reg(8'hc6, 16'h000f);
        wr_reg(8'hc0, 16'h05ff);
        chk("col out", 20'h05, {12'h0, col_out});
        chk("col oe", 20'h0f, {12'h0, col_oe});
        wr_reg(8'hc0, 16'hf0f0);
        chk("col out", 20'h05, {12'h0, col_out});
        wr_reg(8'hc0, 16'hff0a);
        chk("col out", 20'h0a, {12'h0, col_out});
        ext_val = 20'h0_00a0;
        wait_n(3);
        rd_chk(8'hc0, 16'hffaa);
        wr_reg(8'hc4, 16'hf8f8);
        chk("row out", 20'h800, {8'h0, row_out});
        wait_n(3);
        rd_chk(8'hc4, 16'h0808);
        wr_reg(8'hc7, 16'h00ff);
        wr_reg(8'hc2, 16'h3c5a);
        chk("row out", 20'h818, {8'h0, row_out});
        chk("row oe", 20'h8ff, {8'h0, row_oe});
        wait_n(3);
        rd_chk(8'hc2, 16'h3c18);
        wr_reg(8'hc8, 16'h00ff);
        rd_chk(8'hc8, 16'h000f);
        chk("row oe", 20'hfff, {8'h0, row_oe});
        wr_reg(8'hcb, 16'hffff);
        rd_chk(8'hcb, 16'h000f);
        ext_val = 20'h0_0020;
        wait_n(4);
        chk("falling edge", 20'h0, irq);
        ext_val = 20'h0_00a0;
        wait_n(3);
        chk("rising edge", 20'h0_0080, irq);
        wait_n(1);
        chk("edge pulse end", 20'h0, irq);
        wr_reg(8'hc9, 16'h0080);
        wait_n(3);
        for (int i = 0; i < 4; i++) begin
            wait_n(1);
            chk("level hold", 20'h0_0080, irq);
        end
        wr_reg(8'hcf, 16'h007f);
        wait_n(4);
        chk("low active high pin", 20'h0, irq);
        ext_val = 20'h0_0020;
        wait_n(4);
        chk("low active low pin", 20'h0_0080, irq);
        wr_reg(8'hc3, 16'hffff);
        chk("unmapped write", 20'h818, {8'h0, row_out});
        rd_chk(8'hc6, 16'h000f);
        // reset in mid-run with column pin 5 held high
        rst_b_i = 1'b0;
        wait_n(3);
        chk("oe mid reset", 20'h8_0000, {row_oe, col_oe});
        chk("out mid reset", 20'h0, {row_out, col_out});
        rst_b_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            wait_n(1);
            chk("no edge after reset", 20'h0, irq);
        end
        rd_chk(8'hc0, 16'h0020);
        end_of_test();
    end
endmodule

// *** tb/gds_pins_model.sv ***
// external circuitry on the keypad column and row pins
// resolves each pin from device drive and bench drive; floating pins toggle
`timescale 1ns/1ps
module gds_pins_model
    import gds_pkg::*;
(
    // clock
    input wire logic mclk_i,
    // device drive
    input wire logic [GDS_PIN_N-1:0] dev_out_i,
    input wire logic [GDS_PIN_N-1:0] dev_oe_i,
    // outside drive
    input wire logic [GDS_PIN_N-1:0] ext_en_i,
    input wire logic [GDS_PIN_N-1:0] ext_val_i,
    // resolved levels
    output logic [GDS_PIN_N-1:0] lvl_o
);
    logic flt_r = 1'b0;
    always @(posedge mclk_i) flt_r <= ~flt_r;
    // undriven pins never hold a stale level
    assign lvl_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_en_i & ext_val_i)
                 | (~dev_oe_i & ~ext_en_i & {GDS_PIN_N{flt_r}});
endmodule
